/* tb/vhsc_host_model.sv */
/*
 Host model driving the serial register port: frames, address, items.
 Assumes a 200 MHz bench clock; one serial bit spans 25 clocks.
*/
`timescale 1ns/100ps
module vhsc_host_model (
   input wire i_clk,
   input wire i_miso,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_mosi
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // ----------------------------------------
   // Serial port transfers
   // ----------------------------------------
   // Clock stands low outside frames; data changes in the low phase
   task automatic bitx(input logic b, output logic r);
      @(negedge i_clk);
      o_mosi <= b;
      repeat (11) @(negedge i_clk);
      r = i_miso;
      o_sclk <= 1'b1;
      repeat (13) @(negedge i_clk);
      o_sclk <= 1'b0;
   endtask
   task automatic item(input int n, input logic [15:0] wd, output logic [15:0] rd);
      logic r;
      rd = 16'h0000;
      for (int k = n - 1; k >= 0; k--) begin
         bitx(wd[k], r);
         rd = {rd[14:0], r};
      end
   endtask
   task automatic open_f(input logic [7:0] a);
      logic [15:0] x;
      @(negedge i_clk);
      o_cs_n <= 1'b0;
      repeat (12) @(negedge i_clk);
      item(8, {8'h00, a}, x);
   endtask
   // Released data line shows the inverse so no stale bit passes
   task automatic close_f;
      @(negedge i_clk);
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi;
      repeat (8) @(negedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
      logic [15:0] x;
      open_f(a);
      item(n, d, x);
      close_f();
   endtask
endmodule // vhsc_host_model

/* tb/vhsc_stream_checker.sv */
/*
 Port checker for the stream control block.
 Assumes it is bound to vhsc_stream_ctrl with SAMPLE_CYC passed on.
*/
`timescale 1ns/100ps
module vhsc_stream_checker #(
   parameter int SAMPLE_CYC = 25000
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_spi_cs_n,
   input wire i_spi_sclk,
   input wire i_spi_mosi,
   input wire o_spi_miso,
   input wire [15:0] i_adc_sample,
   input wire [15:0] o_dac_sample,
   input wire o_dac_strobe,
   input wire [15:0] o_prog_data,
   input wire o_prog_strobe,
   input wire o_bias_en,
   input wire o_host_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // ----------------------------------------
   // Tick gap tracking and assertions
   // ----------------------------------------
   logic [31:0] gap_r;
   logic seen_r;
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap_r <= 32'h0;
         seen_r <= 1'b0;
      end else if (o_dac_strobe) begin
         gap_r <= 32'h0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end
   sequence s_cs_idle;
      i_spi_cs_n [*8];
   endsequence
   sequence s_dac_quiet;
      (!o_dac_strobe) [*8];
   endsequence
   a_dac_tick_gap: assert property (o_dac_strobe && seen_r |-> (gap_r + 1) % SAMPLE_CYC == 0)
      else $error("dac strobe off the sample tick");
   a_dac_pulse_once: assert property (o_dac_strobe |=> s_dac_quiet)
      else $error("dac strobe repeats too soon");
   a_dac_data_hold: assert property ($changed(o_dac_sample) |-> o_dac_strobe)
      else $error("dac sample moved without strobe");
   a_prog_data_hold: assert property ($changed(o_prog_data) |-> o_prog_strobe)
      else $error("prog data moved without strobe");
   a_prog_pulse_once: assert property (o_prog_strobe |=> !o_prog_strobe)
      else $error("prog strobe longer than a cycle");
   a_prog_needs_frame: assert property (s_cs_idle |-> !o_prog_strobe)
      else $error("prog strobe with port idle");
   a_bias_needs_frame: assert property (s_cs_idle |=> $stable(o_bias_en))
      else $error("bias moved with port idle");
   a_reset_out_quiet: assert property ($rose(i_rst_n) |->
      !o_dac_strobe && !o_prog_strobe && !o_bias_en && !o_host_irq)
      else $error("outputs active at reset release");
endmodule // vhsc_stream_checker
bind vhsc_stream_ctrl vhsc_stream_checker #(.SAMPLE_CYC(SAMPLE_CYC)) vhsc_stream_checker_inst (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk),
   .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso), .i_adc_sample(i_adc_sample),
   .o_dac_sample(o_dac_sample), .o_dac_strobe(o_dac_strobe), .o_prog_data(o_prog_data),
   .o_prog_strobe(o_prog_strobe), .o_bias_en(o_bias_en), .o_host_irq(o_host_irq)
);

/* tb/vocoder_host_stream_control_test.sv */
/*
 Self-checking bench for the stream control block, mostly pass-through.
 Assumes the host model drives the serial port; sample tick shortened.
*/
`timescale 1ns/100ps
`include "vhsc_regs.vh"
`define CHK(nm, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
   end \
end
module vocoder_host_stream_control_test;
   localparam int SC = 40;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [15:0] adc = 16'h0000;
   logic cap = 1'b0;
   wire cs_n, sclk, mosi, miso, dac_stb, prog_stb, bias, irq;
   wire [15:0] dac, prog;
   int bad_count = 0;
   int samples_checked = 0;
   int prog_cnt = 0;
   logic [15:0] dac_q[$];
   always #2.5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      if (prog_stb === 1'b1)
         prog_cnt++;
      if (cap && dac_stb === 1'b1)
         dac_q.push_back(dac);
   end
   vhsc_stream_ctrl #(.SAMPLE_CYC(SC)) vhsc_stream_ctrl_inst (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .i_adc_sample(adc), .o_dac_sample(dac),
      .o_dac_strobe(dac_stb), .o_prog_data(prog), .o_prog_strobe(prog_stb),
      .o_bias_en(bias), .o_host_irq(irq)
   );
   vhsc_host_model vhsc_host_model_inst (
      .i_clk(i_ref_clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi)
   );
   // ----------------------------------------
   // Shared tasks and scenarios
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      vhsc_host_model_inst.wr(a, d, 16);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      vhsc_host_model_inst.open_f(a);
      vhsc_host_model_inst.item(16, 16'h0000, d);
      vhsc_host_model_inst.close_f();
   endtask
   // One pass-through packet in a single streaming frame
   task automatic send_pkt(input logic [15:0] base);
      logic [15:0] x;
      vhsc_host_model_inst.open_f(`VHSC_PCM_IN_WORD);
      for (int i = 0; i < `VHSC_PASS_PKT_LEN; i++)
         vhsc_host_model_inst.item(16, base + i[15:0], x);
      vhsc_host_model_inst.close_f();
   endtask
   task automatic t_reset_modes;
      logic [15:0] d;
      rd(`VHSC_STATUS_FLAGS, d);
      `CHK("status", 16'h0000, d)
      `CHK("irq", 1'b0, irq)
      rd(8'h20, d);
      `CHK("unmapped", 16'h0000, d)
      for (int m = 0; m < 6; m++) begin
         wr(`VHSC_MODE_CONTROL, {13'h0, m[2:0]});
         rd(`VHSC_STATUS_FLAGS, d);
         `CHK("mode", {13'h0, m[2:0]}, d)
      end
      $display("t_reset_modes done");
   endtask
   task automatic t_pass_host;
      logic [15:0] d;
      wr(`VHSC_AUDIO_ROUTING, 16'h0011); // Host source before any input
      wr(`VHSC_IRQ_ENABLE, 16'h0010);
      wr(`VHSC_MODE_CONTROL, {13'h0, `VHSC_MODE_PASS});
      vhsc_host_model_inst.wr(`VHSC_CODED_IN_BYTE, 16'h0077, 8); // Inactive register
      send_pkt(16'h0100); // First packet needs no handshake
      `CHK("irq wanted", 1'b1, irq)
      rd(`VHSC_STATUS_FLAGS, d);
      `CHK("status", 16'h001c, d)
      `CHK("irq masked", 1'b0, irq)
      wr(`VHSC_IRQ_ENABLE, 16'h0008);
      `CHK("irq ready", 1'b1, irq)
      vhsc_host_model_inst.open_f(`VHSC_PCM_OUT_WORD);
      for (int i = 0; i < `VHSC_PASS_PKT_LEN; i++) begin
         vhsc_host_model_inst.item(16, 16'h0000, d);
         `CHK("pcm out", 16'h0100 + i[15:0], d)
      end
      vhsc_host_model_inst.close_f();
      rd(`VHSC_STATUS_FLAGS, d);
      `CHK("status", 16'h0004, d)
      `CHK("irq idle", 1'b0, irq)
      $display("t_pass_host done");
   endtask
   task automatic t_flush;
      logic [15:0] d;
      send_pkt(16'h0200);
      wr(`VHSC_MODE_CONTROL, {13'h0, `VHSC_MODE_PASS});
      rd(`VHSC_STATUS_FLAGS, d);
      `CHK("status", 16'h0014, d)
      rd(`VHSC_PCM_OUT_WORD, d);
      `CHK("flushed out", 16'h0000, d)
      $display("t_flush done");
   endtask
   task automatic t_adc_src;
      logic [15:0] d;
      adc = 16'h1234;
      wr(`VHSC_AUDIO_ROUTING, 16'h0010); // Analogue source while in pass-through
      wr(`VHSC_MODE_CONTROL, {13'h0, `VHSC_MODE_PASS});
      // Four packets fill all storage at the sample rate; the fifth overflows
      repeat (5 * 16 * SC + 200) @(negedge i_ref_clk);
      rd(`VHSC_STATUS_FLAGS, d);
      `CHK("status", 16'h002c, d & 16'h006f)
      rd(`VHSC_PCM_OUT_WORD, d);
      `CHK("adc word", 16'h1234, d)
      $display("t_adc_src done");
   endtask
   task automatic t_dac_dst;
      logic [15:0] d;
      int n;
      wr(`VHSC_NOISE_GATE_CONFIG, 16'h00ff); // Threshold above every sample
      wr(`VHSC_AUDIO_ROUTING, 16'h0001); // Analogue output in pass-through
      wr(`VHSC_MODE_CONTROL, {13'h0, `VHSC_MODE_PASS});
      cap = 1'b1;
      send_pkt(16'h0001);
      n = 0;
      while (dac_q.size() < 17 && n < 2000) begin
         @(negedge i_ref_clk);
         n++;
      end
      if (n >= 2000) begin
         $display("[FAIL] dac samples expected 17 seen %0d", dac_q.size());
         bad_count++;
         close_out();
      end
      for (int i = 0; i < 16; i++)
         `CHK("dac", 16'h0001 + i[15:0], dac_q[i])
      `CHK("dac empty", 16'h0000, dac_q[16])
      rd(`VHSC_STATUS_FLAGS, d);
      `CHK("underflow", 16'h0040, d & 16'h0040)
      $display("t_dac_dst done");
   endtask
   task automatic t_prog_bias;
      wr(`VHSC_MODE_CONTROL, {13'h0, `VHSC_MODE_IDLE});
      wr(`VHSC_PROGRAM_BLOCK_ACCESS, 16'ha5c3);
      `CHK("prog", 16'ha5c3, prog)
      wr(`VHSC_MODE_CONTROL, {13'h0, `VHSC_MODE_PASS});
      wr(`VHSC_PROGRAM_BLOCK_ACCESS, 16'h1111);
      `CHK("prog kept", 16'ha5c3, prog)
      `CHK("prog count", 1, prog_cnt)
      wr(`VHSC_ANALOGUE_BIAS_CONTROL, 16'h0001);
      `CHK("bias on", 1'b1, bias)
      wr(`VHSC_ANALOGUE_BIAS_CONTROL, 16'h0000);
      `CHK("bias off", 1'b0, bias)
      $display("t_prog_bias done");
   endtask
   initial begin
      repeat (6) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      t_reset_modes();
      t_pass_host();
      t_flush();
      t_adc_src();
      t_dac_dst();
      t_prog_bias();
      close_out();
   end
endmodule // vocoder_host_stream_control_test

/* verilog/vhsc_regs.vh */
/*
 Register offsets, field positions, mode codes, packet sizes and timing
 constants for the vocoder host stream control block.
 Included by both the bench and the block; guarded against double inclusion.
*/
`ifndef VHSC_REGS_VH
`define VHSC_REGS_VH

// ----------------------------------------
// Register offsets (serial port addresses)
// ----------------------------------------
`define VHSC_CODED_IN_BYTE 8'h48
`define VHSC_PCM_IN_WORD 8'h49
`define VHSC_CODED_OUT_BYTE 8'h4c
`define VHSC_PCM_OUT_WORD 8'h4d
`define VHSC_NOISE_SUPPRESS_LEVEL 8'h53
`define VHSC_AUDIO_ROUTING 8'h5d
`define VHSC_NOISE_GATE_CONFIG 8'h5e
`define VHSC_PROGRAM_BLOCK_ACCESS 8'h6a
`define VHSC_MODE_CONTROL 8'h6b
`define VHSC_IRQ_ENABLE 8'h6c
`define VHSC_STATUS_FLAGS 8'h7e
`define VHSC_ANALOGUE_BIAS_CONTROL 8'hb7

// ----------------------------------------
// Mode codes, mode_control[2:0]
// ----------------------------------------
`define VHSC_MODE_IDLE 3'h0
`define VHSC_MODE_DECODE 3'h1
`define VHSC_MODE_ENCODE 3'h2
`define VHSC_MODE_ENC_DEC 3'h3
`define VHSC_MODE_PASS 3'h4
`define VHSC_MODE_ECC_LOOP 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VHSC_RT_SRC_HOST_BIT 0
`define VHSC_RT_DST_HOST_BIT 4
`define VHSC_ST_OUTPUT_AVAILABLE_BIT 3
`define VHSC_ST_INPUT_WANTED_BIT 4
`define VHSC_ST_OVERFLOW_BIT 5
`define VHSC_ST_UNDERFLOW_BIT 6
`define VHSC_BIAS_EN_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VHSC_RST_MODE 3'h0
`define VHSC_RST_ROUTING 16'h0011
`define VHSC_RST_WORD 16'h0000

// ----------------------------------------
// Packet sizes, in items
// ----------------------------------------
`define VHSC_PCM_PKT_LEN 9'd160
`define VHSC_CODED_PKT_LEN 9'd36
`define VHSC_PASS_PKT_LEN 9'd16

// ----------------------------------------
// Timing
// ----------------------------------------
`define VHSC_REF_CLK_HZ 200000000
`define VHSC_SAMPLE_RATE_HZ 8000

`endif

/* verilog/vhsc_stream_ctrl.v */
/*
 Vocoder host stream control: serial register port, mode control,
 two-packet input and output storage, analogue 8 kHz sample paths,
 noise suppression, noise gate, programming and bias outputs, host irq.
 Assumes the serial port pins come from another clock domain and the
 analogue converters accept one sample per tick.
*/
// What this block does
// R1: Any mode write flushes input and output registers and buffers.
// R2: Host selects host-port input in routing before writing input.
// R3: Input-wanted set when a packet is taken; host writes two freely.
// R4: Analogue source loads input buffer by itself.
// R5: Host picks analogue input only in encode, enc-dec, pass-through.
// R6: Analogue input samples at fixed 8 kHz.
// R7: Analogue in, host out: slow reads flag data overflow.
// R8: Processed packet goes to output register, sets output-available.
// R9: Analogue destination drains output buffer by itself.
// R10: Host picks analogue output only in decode, enc-dec, pass-through.
// R11: Analogue output plays at fixed 8 kHz.
// R12: Host in, analogue out: slow writes flag data underflow.
// R13: Encoder noise suppression strength from its level register.
// R14: Enabled noise gate mutes output once amplitude has stayed below threshold for the delay count.
// R15: Noise gate works only in decode and enc-dec modes.
// R16: Gate uses threshold and delay fields of its config register.
// R17: Mode control picks idle, encode, decode, enc-dec, pass, loop.
// R18: Error-correction loop mode re-codes coded packets; the block copies them unchanged.
// R19: Enc-dec mode encodes then decodes PCM back to audio; the block copies PCM, applying only suppression and gate.
// R20: Programming register writes accepted only in idle mode.
// R21: Host enables bias before analogue blocks work.
// R22: Interrupt on input wanted or output ready, under irq enable.
// R23: Two packets per direction; when full stop and flag overflow.
// R24: Encoding sets input-wanted when last frame processing begins.
// R25: One input and one output streaming register active at once.
`timescale 1ns/100ps
`include "vhsc_regs.vh"

module vhsc_stream_ctrl #(
   parameter SAMPLE_CYC = `VHSC_REF_CLK_HZ / `VHSC_SAMPLE_RATE_HZ
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_spi_cs_n,
   input wire i_spi_sclk,
   input wire i_spi_mosi,
   output wire o_spi_miso,
   input wire [15:0] i_adc_sample,
   output wire [15:0] o_dac_sample,
   output wire o_dac_strobe,
   output wire [15:0] o_prog_data,
   output wire o_prog_strobe,
   output wire o_bias_en,
   output wire o_host_irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [8:0] mem_addr;
      input slot;
      input [8:0] idx;
      begin
         mem_addr = slot ? (idx + `VHSC_PCM_PKT_LEN) : idx;
      end
   endfunction

   function [16:0] mag;
      input [15:0] x;
      begin
         mag = x[15] ? (17'h10000 - {1'b0, x}) : {1'b0, x};
      end
   endfunction

   localparam SP_ADDR = 1'b0;
   localparam SP_DATA = 1'b1;

   // ----------------------------------------
   // Pin synchronisers: csn, sclk, mosi
   // ----------------------------------------
   reg [2:0] sy1_r, sy2_r, sy3_r, pin_r;
   wire [2:0] pin_nxt = (sy2_r & sy3_r) | (pin_r & (sy2_r ^ sy3_r));
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sy1_r <= 3'h7;
         sy2_r <= 3'h7;
         sy3_r <= 3'h7;
         pin_r <= 3'h7;
      end else begin
         sy1_r <= {i_spi_cs_n, i_spi_sclk, i_spi_mosi};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         pin_r <= pin_nxt;
      end
   end
   wire cs_on = ~pin_r[2];
   wire sck_rise = cs_on & pin_nxt[1] & ~pin_r[1];
   wire sck_fall = cs_on & ~pin_nxt[1] & pin_r[1];

   // ----------------------------------------
   // Serial register port
   // ----------------------------------------
   reg sp_state_r;
   reg [4:0] bit_cnt_r;
   reg [7:0] addr_r;
   reg [15:0] rx_r, tx_r;
   reg wr_stb_r, rd_stb_r, reload_r, hold_r;
   wire [15:0] rd_word;
   // Byte-wide streaming registers carry 8 data bits, all others 16
   wire byte_reg = (addr_r == `VHSC_CODED_IN_BYTE) | (addr_r == `VHSC_CODED_OUT_BYTE);
   wire [4:0] dlast = byte_reg ? 5'd7 : 5'd15;
   wire [15:0] tx_load = byte_reg ? {rd_word[7:0], 8'h00} : rd_word;
   wire [7:0] addr_nxt = {addr_r[6:0], pin_r[0]};

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp_state_r <= SP_ADDR;
         bit_cnt_r <= 5'd0;
         addr_r <= 8'h00;
         rx_r <= 16'h0000;
         tx_r <= 16'h0000;
         wr_stb_r <= 1'b0;
         rd_stb_r <= 1'b0;
         reload_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         rd_stb_r <= 1'b0;
         reload_r <= rd_stb_r;
         if (!cs_on) begin
            sp_state_r <= SP_ADDR;
            bit_cnt_r <= 5'd0;
         end else if (sck_rise) begin
            case (sp_state_r)
               SP_ADDR: begin
                  addr_r <= addr_nxt;
                  bit_cnt_r <= bit_cnt_r + 5'd1;
                  if (bit_cnt_r == 5'd7) begin
                     sp_state_r <= SP_DATA;
                     bit_cnt_r <= 5'd0;
                     reload_r <= 1'b1;
                  end
               end
               SP_DATA: begin
                  rx_r <= {rx_r[14:0], pin_r[0]};
                  bit_cnt_r <= bit_cnt_r + 5'd1;
                  // Streaming: stay on the same address for the next item
                  if (bit_cnt_r == dlast) begin
                     bit_cnt_r <= 5'd0;
                     wr_stb_r <= 1'b1;
                     rd_stb_r <= 1'b1;
                  end
               end
               default: sp_state_r <= SP_ADDR;
            endcase
         end
         if (reload_r)
            tx_r <= tx_load;
         else if (sck_fall && sp_state_r == SP_DATA && !hold_r)
            tx_r <= {tx_r[14:0], 1'b0};
         if (reload_r | sck_fall)
            hold_r <= reload_r; // Fresh item outlives the fall closing the prior bit
      end
   end
   assign o_spi_miso = tx_r[15];
   wire [15:0] wr_data = byte_reg ? {8'h00, rx_r[7:0]} : rx_r;
   wire wr_at_addr = wr_stb_r;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   reg [2:0] mode_r;
   reg [15:0] routing_r, ns_level_r, ng_cfg_r, irq_en_r, prog_r;
   reg prog_stb_r, bias_r, mode_wr_r;
   wire mode_idle = (mode_r == `VHSC_MODE_IDLE);
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_r <= `VHSC_RST_MODE;
         routing_r <= `VHSC_RST_ROUTING;
         ns_level_r <= `VHSC_RST_WORD;
         ng_cfg_r <= `VHSC_RST_WORD;
         irq_en_r <= `VHSC_RST_WORD;
         prog_r <= `VHSC_RST_WORD;
         prog_stb_r <= 1'b0;
         bias_r <= 1'b0;
         mode_wr_r <= 1'b0;
      end else begin
         prog_stb_r <= 1'b0;
         mode_wr_r <= 1'b0;
         if (wr_at_addr) begin
            case (addr_r)
               `VHSC_MODE_CONTROL: begin
                  mode_r <= wr_data[2:0]; // [R17]
                  mode_wr_r <= 1'b1; // [R1]
               end
               `VHSC_AUDIO_ROUTING: routing_r <= wr_data;
               `VHSC_NOISE_SUPPRESS_LEVEL: ns_level_r <= wr_data; // [R13]
               `VHSC_NOISE_GATE_CONFIG: ng_cfg_r <= wr_data; // [R16]
               `VHSC_IRQ_ENABLE: irq_en_r <= wr_data;
               `VHSC_ANALOGUE_BIAS_CONTROL: bias_r <= wr_data[`VHSC_BIAS_EN_BIT];
               `VHSC_PROGRAM_BLOCK_ACCESS: begin
                  if (mode_idle) begin // [R20]
                     prog_r <= wr_data;
                     prog_stb_r <= 1'b1;
                  end
               end
               default: prog_stb_r <= 1'b0;
            endcase
         end
      end
   end
   assign o_prog_data = prog_r;
   assign o_prog_strobe = prog_stb_r;
   assign o_bias_en = bias_r;

   // ----------------------------------------
   // Mode decode and active register choice
   // ----------------------------------------
   wire m_pass = (mode_r == `VHSC_MODE_PASS);
   wire m_loop = (mode_r == `VHSC_MODE_ECC_LOOP); // [R18]
   wire m_enc = (mode_r == `VHSC_MODE_ENCODE);
   wire m_dec = (mode_r == `VHSC_MODE_DECODE);
   wire m_encdec = (mode_r == `VHSC_MODE_ENC_DEC); // [R19]
   wire coded_in_sel = m_dec | m_loop; // [R25]
   wire coded_out_sel = m_enc | m_loop; // [R25]
   wire [8:0] in_len = m_pass ? `VHSC_PASS_PKT_LEN :
                       coded_in_sel ? `VHSC_CODED_PKT_LEN : `VHSC_PCM_PKT_LEN;
   wire [8:0] out_len = m_pass ? `VHSC_PASS_PKT_LEN :
                        coded_out_sel ? `VHSC_CODED_PKT_LEN : `VHSC_PCM_PKT_LEN;
   wire src_host = routing_r[`VHSC_RT_SRC_HOST_BIT];
   wire dst_host = routing_r[`VHSC_RT_DST_HOST_BIT];
   wire [7:0] in_reg = coded_in_sel ? `VHSC_CODED_IN_BYTE : `VHSC_PCM_IN_WORD;
   wire [7:0] out_reg = coded_out_sel ? `VHSC_CODED_OUT_BYTE : `VHSC_PCM_OUT_WORD;

   // ----------------------------------------
   // 8 kHz sample tick, free running
   // ----------------------------------------
   reg [15:0] tick_cnt_r;
   wire tick = (tick_cnt_r == SAMPLE_CYC[15:0] - 16'd1);
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         tick_cnt_r <= 16'h0000;
      else
         tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'd1; // [R6] [R11]
   end

   // ----------------------------------------
   // Packet storage, two packets each way
   // ----------------------------------------
   reg [15:0] in_mem [0:319];
   reg [15:0] out_mem [0:319];
   reg [1:0] in_pkts_r, out_pkts_r;
   reg [8:0] in_widx_r, out_ridx_r, proc_idx_r, src_idx_r;
   reg in_wslot_r, in_rslot_r, out_wslot_r, out_rslot_r;
   reg busy_r, dac_run_r;
   reg idw_r, ovf_r, unf_r;
   reg [15:0] dac_r;
   reg dac_stb_r;
   reg [7:0] gate_cnt_r;

   wire active = ~mode_idle;
   // Analogue source fills input buffer with no host traffic
   wire in_push = active & (src_host ? (wr_at_addr & addr_r == in_reg) : tick); // [R4]
   wire [15:0] in_data = src_host ? wr_data : i_adc_sample;
   wire in_full = (in_pkts_r == 2'd2);
   wire in_done = in_push & ~in_full & (in_widx_r == in_len - 9'd1);
   wire start = active & ~busy_r & (in_pkts_r != 2'd0) & (out_pkts_r != 2'd2); // [R23]
   wire proc_last = busy_r & (proc_idx_r == out_len - 9'd1);
   wire host_pop = dst_host & rd_stb_r & (addr_r == out_reg);
   wire dac_pop = ~dst_host & tick & dac_run_r; // [R9]
   wire out_empty = (out_pkts_r == 2'd0);
   wire out_pop = active & (host_pop | dac_pop) & ~out_empty;
   wire pop_last = out_pop & (out_ridx_r == out_len - 9'd1);
   wire status_rd = rd_stb_r & (addr_r == `VHSC_STATUS_FLAGS);

   // ----------------------------------------
   // Sample shaping: suppression and gate
   // ----------------------------------------
   wire [15:0] src_word = in_mem[mem_addr(in_rslot_r, src_idx_r)];
   // Halving small samples reduces the floor without removing it
   wire ns_on = (m_enc | m_encdec) & (ns_level_r != 16'h0000);
   wire [15:0] ns_word = (ns_on & mag(src_word) < {1'b0, ns_level_r}) ?
                         {src_word[15], src_word[15:1]} : src_word; // [R13]
   wire gate_on = (m_dec | m_encdec) & (ng_cfg_r[7:0] != 8'h00); // [R15]
   wire gate_low = mag(ns_word) < {2'b00, ng_cfg_r[7:0], 7'h00}; // [R16]
   wire gate_mute = gate_on & gate_low & (gate_cnt_r >= ng_cfg_r[15:8]); // [R14]
   wire [15:0] proc_word = gate_mute ? 16'h0000 : ns_word;

   always @(posedge i_ref_clk) begin
      if (in_push & ~in_full)
         in_mem[mem_addr(in_wslot_r, in_widx_r)] <= in_data;
      if (busy_r)
         out_mem[mem_addr(out_wslot_r, proc_idx_r)] <= proc_word;
   end

   assign rd_word = (addr_r == `VHSC_STATUS_FLAGS) ?
                    {9'h000, unf_r, ovf_r, idw_r, ~out_empty, mode_r} :
                    (addr_r == out_reg & ~out_empty) ?
                    out_mem[mem_addr(out_rslot_r, out_ridx_r)] : 16'h0000;

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_pkts_r <= 2'd0;
         out_pkts_r <= 2'd0;
         in_widx_r <= 9'd0;
         out_ridx_r <= 9'd0;
         proc_idx_r <= 9'd0;
         src_idx_r <= 9'd0;
         in_wslot_r <= 1'b0;
         in_rslot_r <= 1'b0;
         out_wslot_r <= 1'b0;
         out_rslot_r <= 1'b0;
         busy_r <= 1'b0;
         dac_run_r <= 1'b0;
         idw_r <= 1'b0;
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
         dac_r <= 16'h0000;
         dac_stb_r <= 1'b0;
         gate_cnt_r <= 8'h00;
      end else begin
         dac_stb_r <= 1'b0;
         // Status read clears sticky flags; a same-cycle set wins below
         if (status_rd) begin
            idw_r <= 1'b0;
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
         end
         if (mode_wr_r) begin // [R1]
            in_pkts_r <= 2'd0;
            out_pkts_r <= 2'd0;
            in_widx_r <= 9'd0;
            out_ridx_r <= 9'd0;
            in_wslot_r <= 1'b0;
            in_rslot_r <= 1'b0;
            out_wslot_r <= 1'b0;
            out_rslot_r <= 1'b0;
            busy_r <= 1'b0;
            dac_run_r <= 1'b0;
            gate_cnt_r <= 8'h00;
         end else begin
            if (in_push) begin
               if (in_full)
                  ovf_r <= 1'b1; // [R23] [R7]
               else if (in_done) begin
                  in_widx_r <= 9'd0;
                  in_wslot_r <= ~in_wslot_r;
               end else
                  in_widx_r <= in_widx_r + 9'd1;
            end
            if (start) begin
               busy_r <= 1'b1;
               proc_idx_r <= 9'd0;
               src_idx_r <= 9'd0;
               idw_r <= 1'b1; // [R3] [R24]
            end
            if (busy_r) begin
               proc_idx_r <= proc_idx_r + 9'd1;
               src_idx_r <= (src_idx_r == in_len - 9'd1) ? 9'd0 : src_idx_r + 9'd1;
               gate_cnt_r <= ~gate_low ? 8'h00 :
                             (gate_cnt_r == 8'hff) ? gate_cnt_r : gate_cnt_r + 8'd1;
            end
            if (proc_last) begin // [R8]
               busy_r <= 1'b0;
               in_rslot_r <= ~in_rslot_r;
               out_wslot_r <= ~out_wslot_r;
               if (~dst_host)
                  dac_run_r <= 1'b1;
            end
            in_pkts_r <= in_pkts_r + {1'b0, in_done} - {1'b0, proc_last};
            out_pkts_r <= out_pkts_r + {1'b0, proc_last} - {1'b0, pop_last};
            if (out_pop) begin
               out_ridx_r <= pop_last ? 9'd0 : out_ridx_r + 9'd1;
               if (pop_last)
                  out_rslot_r <= ~out_rslot_r;
            end
            if (dac_pop) begin
               dac_stb_r <= 1'b1;
               dac_r <= out_empty ? 16'h0000 : out_mem[mem_addr(out_rslot_r, out_ridx_r)];
               if (out_empty)
                  unf_r <= 1'b1; // [R12]
            end
            if (active & ~dst_host & tick & ~dac_run_r & ~busy_r & out_empty
                & src_host & in_pkts_r == 2'd0 & in_widx_r != 9'd0)
               unf_r <= 1'b1; // [R12]
         end
      end
   end
   assign o_dac_sample = dac_r;
   assign o_dac_strobe = dac_stb_r;

   // ----------------------------------------
   // Host interrupt
   // ----------------------------------------
   assign o_host_irq = (irq_en_r[`VHSC_ST_INPUT_WANTED_BIT] & idw_r) |
                       (irq_en_r[`VHSC_ST_OUTPUT_AVAILABLE_BIT] & ~out_empty); // [R22]

endmodule // vhsc_stream_ctrl
